// file: core/sram_pkg.sv
// shared constants and carrier types for the burst sram core
package sram_pkg;
  localparam int NUM_LANES = 2;
  localparam int LANE_W = 9;
  localparam int ADDR_W_DEF = 18;
  localparam int BURST_W = 2;
  localparam logic [BURST_W-1:0] CNT_RESET = 2'h0;
  localparam logic [BURST_W-1:0] CNT_STEP = 2'h1;
  localparam logic INTERLEAVE_RESET = 1'b1;
  localparam logic SLEEP_RESET = 1'b0;

  typedef enum logic [0:0] {
    ORDER_LINEAR = 1'b0,
    ORDER_INTERLEAVED = 1'b1
  } burst_order_t;

  // synchronous control pins, all sampled on the rising clock edge
  typedef struct packed {
    logic processor_addr_strobe_n;
    logic controller_addr_strobe_n;
    logic burst_advance_n;
    logic chip_select_first_n;
    logic chip_select_second;
    logic chip_select_third_n;
    logic global_write_n;
    logic byte_write_enable_n;
    logic [NUM_LANES-1:0] byte_lane_select_n;
  } bus_ctrl_t;
endpackage

// file: core/sram_array.sv
// storage array with per-lane write and a registered read port
`timescale 1ns/1ps
module sram_array #(
  parameter int AW = 18,
  parameter int LW = 9,
  parameter int LANES = 2
) (
  input wire logic core_clk_in,
  input wire logic rst_n_in,
  input wire logic [LANES-1:0] lane_we_in,
  input wire logic [AW-1:0] waddr_in,
  input wire logic [LANES*LW-1:0] wdata_in,
  input wire logic [AW-1:0] raddr_in,
  output logic [LANES*LW-1:0] rdata_out
);
  logic [LANES-1:0][LW-1:0] rd_q;

  if (AW < 1 || LW < 1 || LANES < 1) begin : g_bad_param
    $error("array needs nonzero address width, lane width and lanes");
  end

  // array itself has no reset: contents survive sleep and reset alike
  // one memory per lane, so each lane has a single writing process
  for (genvar l = 0; l < LANES; l++) begin : g_lane
    logic [LW-1:0] mem [0:(1<<AW)-1];
    always_ff @(posedge core_clk_in) begin
      if (lane_we_in[l]) begin
        mem[waddr_in] <= wdata_in[l*LW +: LW];
      end
    end
    // read-first: a same-edge write shows up on the next read
    always_ff @(posedge core_clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
        rd_q[l] <= '0;
      end else begin
        rd_q[l] <= mem[raddr_in];
      end
    end
  end

  assign rdata_out = rd_q;
endmodule

// file: core/burst_sram_core.sv
// pipelined burst sram core: strobes, burst counter, writes, output drive
`timescale 1ns/1ps
module burst_sram_core
  import sram_pkg::*;
#(
  parameter int ADDR_W = sram_pkg::ADDR_W_DEF
) (
  input wire logic core_clk_in,
  input wire logic rst_n_in,
  input wire sram_pkg::bus_ctrl_t ctrl_in,
  input wire logic [ADDR_W-1:0] addr_in,
  input wire logic output_enable_n_in,
  input wire logic sleep_request_in,
  input wire logic burst_order_strap_in,
  input wire logic [sram_pkg::NUM_LANES*sram_pkg::LANE_W-1:0] data_in,
  output logic [sram_pkg::NUM_LANES*sram_pkg::LANE_W-1:0] data_out,
  output logic data_oe_n_out
);
  import sram_pkg::*;

  if (ADDR_W < BURST_W + 1) begin : g_bad_width
    $error("address too narrow for the burst counter");
  end

  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [BURST_W-1:0] start;
    logic [BURST_W-1:0] cnt;
    logic active;
    logic rd;
    logic drive;
    logic sleep_s1;
    logic sleep_s2;
    logic order_s1;
    burst_order_t order;
  } state_t;

  state_t st_q;
  state_t st_d;
  logic [NUM_LANES-1:0] lane_we;
  logic [NUM_LANES-1:0] byte_mask;
  logic sel_ok;
  logic proc_ok;
  logic strobe;
  logic wr_now;
  logic [ADDR_W-1:0] waddr;
  logic [ADDR_W-1:0] raddr;

  function automatic logic [BURST_W-1:0] burst_offset(
    input logic [BURST_W-1:0] start,
    input logic [BURST_W-1:0] cnt,
    input burst_order_t order
  );
    // two-bit arithmetic wraps inside the group of four
    if (order == ORDER_INTERLEAVED) begin
      burst_offset = start ^ cnt;
    end else begin
      burst_offset = start + cnt;
    end
  endfunction

  always_comb begin
    st_d = st_q;
    st_d.sleep_s1 = sleep_request_in;
    st_d.sleep_s2 = st_q.sleep_s1;
    st_d.order_s1 = burst_order_strap_in;
    // strap is static; a floating strap is pulled high outside
    st_d.order = burst_order_t'(st_q.order_s1);
    sel_ok = !ctrl_in.chip_select_first_n && ctrl_in.chip_select_second &&
             !ctrl_in.chip_select_third_n;
    proc_ok = !ctrl_in.processor_addr_strobe_n &&
              !ctrl_in.chip_select_first_n;
    strobe = proc_ok || !ctrl_in.controller_addr_strobe_n;
    if (!ctrl_in.global_write_n) begin
      byte_mask = '1;
    end else if (!ctrl_in.byte_write_enable_n) begin
      byte_mask = ~ctrl_in.byte_lane_select_n;
    end else begin
      byte_mask = '0;
    end
    lane_we = '0;
    if (st_q.sleep_s2) begin
      // asleep: pins ignored, outputs parked, array untouched
      st_d.active = 1'b0;
    end else if (strobe) begin
      st_d.addr = addr_in;
      st_d.start = addr_in[BURST_W-1:0];
      st_d.cnt = CNT_RESET;
      st_d.active = sel_ok;
      if (sel_ok && !proc_ok) begin
        // processor strobe wins and defers write controls a cycle
        lane_we = byte_mask;
      end
    end else if (st_q.active) begin
      if (!ctrl_in.burst_advance_n) begin
        st_d.cnt = st_q.cnt + CNT_STEP;
      end
      lane_we = byte_mask;
    end
    wr_now = |lane_we;
    st_d.rd = st_d.active && !wr_now;
    // drive needs a read at the previous edge and no deselect now
    st_d.drive = st_q.rd && st_d.active && !wr_now;
    waddr = {st_d.addr[ADDR_W-1:BURST_W],
             burst_offset(st_d.start, st_d.cnt, st_d.order)};
    raddr = {st_q.addr[ADDR_W-1:BURST_W],
             burst_offset(st_q.start, st_q.cnt, st_q.order)};
  end

  always_ff @(posedge core_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      st_q <= '{addr: '0, start: CNT_RESET, cnt: CNT_RESET, active: 1'b0,
                rd: 1'b0, drive: 1'b0, sleep_s1: SLEEP_RESET,
                sleep_s2: SLEEP_RESET, order_s1: INTERLEAVE_RESET,
                order: burst_order_t'(INTERLEAVE_RESET)};
    end else begin
      st_q <= st_d;
    end
  end

  // read port is addressed by the registered address: one extra cycle
  sram_array #(
    .AW(ADDR_W),
    .LW(LANE_W),
    .LANES(NUM_LANES)
  ) u_array (
    .core_clk_in(core_clk_in),
    .rst_n_in(rst_n_in),
    .lane_we_in(lane_we),
    .waddr_in(waddr),
    .wdata_in(data_in),
    .raddr_in(raddr),
    .rdata_out(data_out)
  );

  // output enable stays asynchronous, so it gates the drive directly
  assign data_oe_n_out = !(st_q.drive && !output_enable_n_in &&
                           !st_q.sleep_s2);

  default clocking cb @(posedge core_clk_in); endclocking
  default disable iff (!rst_n_in);

  sequence seq_awake_strobe;
    !st_q.sleep_s2 && strobe;
  endsequence

  sequence seq_wake_read;
    !st_q.active ##1 (st_q.active && st_q.rd);
  endsequence

  sequence seq_read_pair;
    st_q.rd ##1 (st_q.active && st_q.rd && !output_enable_n_in &&
                 !st_q.sleep_s2);
  endsequence

  chk_global_all_lanes: assert property (
    (!st_q.sleep_s2 && !ctrl_in.global_write_n && st_q.active && !strobe)
    |-> lane_we == '1) else $error("global write missed a lane");

  chk_byte_enable_gate: assert property (
    (ctrl_in.global_write_n && ctrl_in.byte_write_enable_n)
    |-> lane_we == '0) else $error("write without write enable");

  chk_lane_select: assert property (
    (ctrl_in.global_write_n && !ctrl_in.byte_write_enable_n && wr_now)
    |-> lane_we == ~ctrl_in.byte_lane_select_n)
    else $error("byte write touched wrong lanes");

  chk_advance_step: assert property (
    (!st_q.sleep_s2 && !strobe && st_q.active && !ctrl_in.burst_advance_n)
    |=> st_q.cnt == $past(st_q.cnt) + 2'h1)
    else $error("burst counter did not step");

  chk_select_decode: assert property (
    (seq_awake_strobe and !sel_ok) |=> !st_q.active)
    else $error("active while not selected");

  chk_proc_ignored: assert property (
    (!st_q.sleep_s2 && ctrl_in.chip_select_first_n &&
     ctrl_in.controller_addr_strobe_n) |=> st_q.addr == $past(st_q.addr))
    else $error("processor strobe taken with first select high");

  chk_strobe_load: assert property (
    seq_awake_strobe |=> (st_q.addr == $past(addr_in) &&
                          st_q.cnt == 2'h0))
    else $error("address or counter not loaded");

  chk_proc_priority: assert property (
    (proc_ok && !ctrl_in.controller_addr_strobe_n) |-> lane_we == '0)
    else $error("controller strobe acted on beside processor strobe");

  chk_oe_float: assert property (
    output_enable_n_in |-> data_oe_n_out)
    else $error("pins driven with output enable high");

  chk_first_read_float: assert property (
    seq_wake_read |-> data_oe_n_out)
    else $error("pins driven on first read cycle");

  chk_read_drive: assert property (
    seq_read_pair |-> !data_oe_n_out)
    else $error("read data not presented");

  chk_deselect_float: assert property (
    (seq_awake_strobe and !sel_ok) |=> data_oe_n_out [*2])
    else $error("pins driven after deselect");

  chk_sleep_quiet: assert property (
    st_q.sleep_s2 |-> (lane_we == '0 && data_oe_n_out))
    else $error("activity during sleep");
endmodule

// file: testbench/bus_master_model.sv
// bus master partner: drives control, address and data, resolves the data wire
`timescale 1ns/1ps
module bus_master_model
  import sram_pkg::*;
(
  input wire logic clk_in,
  input wire logic [17:0] dut_data_in,
  input wire logic dut_oe_n_in,
  output sram_pkg::bus_ctrl_t ctrl_out,
  output logic [17:0] addr_out,
  output logic oe_n_out,
  output logic sleep_out,
  output logic strap_out,
  output logic [17:0] wire_out
);
  logic [17:0] wdat_q;
  logic [17:0] idle_q;
  logic drv_q;
  logic oe_lvl;
  initial begin
    ctrl_out = 10'h3af;
    addr_out = 18'h0;
    oe_n_out = 1'b0;
    oe_lvl = 1'b0;
    sleep_out = 1'b0;
    strap_out = 1'b1;
    wdat_q = 18'h0;
    idle_q = 18'h0;
    drv_q = 1'b0;
  end
  // released wire toggles so a stale value never reads back as a match
  assign wire_out = !dut_oe_n_in ? dut_data_in : drv_q ? wdat_q : idle_q;
  always @(posedge clk_in) begin
    idle_q <= ~wire_out;
  end
  // one bus cycle; output enable raised while this side drives write data
  task automatic step(input bus_ctrl_t c, input logic [17:0] a, d);
    logic w;
    w = !(c.global_write_n && c.byte_write_enable_n);
    @(posedge clk_in);
    ctrl_out <= c;
    addr_out <= a;
    wdat_q <= d;
    drv_q <= w;
    oe_n_out <= w ? 1'b1 : oe_lvl;
    #1;
  endtask
endmodule

// file: testbench/tb.sv
// self-checking bench for the burst sram core
`timescale 1ns/1ps
module tb;
  import sram_pkg::*;
  logic core_clk;
  logic rst_n;
  bus_ctrl_t ctrl;
  logic [17:0] addr;
  logic oe_n;
  logic sleep;
  logic strap;
  logic [17:0] bus;
  logic [17:0] dout;
  logic doe_n;
  int error_cnt = 0;
  int tests_run = 0;
  int cycles = 0;
  bus_master_model i_m (.clk_in(core_clk), .dut_data_in(dout),
    .dut_oe_n_in(doe_n), .ctrl_out(ctrl), .addr_out(addr), .oe_n_out(oe_n),
    .sleep_out(sleep), .strap_out(strap), .wire_out(bus));
  burst_sram_core i_dut (.core_clk_in(core_clk), .rst_n_in(rst_n),
    .ctrl_in(ctrl), .addr_in(addr), .output_enable_n_in(oe_n),
    .sleep_request_in(sleep), .burst_order_strap_in(strap), .data_in(bus),
    .data_out(dout), .data_oe_n_out(doe_n));
  task automatic chk(input string what, input logic [17:0] exp, got);
    tests_run++;
    if (got !== exp) begin
      error_cnt++;
      $display("MISMATCH %s exp %h got %h", what, exp, got);
    end
  endtask
  task automatic rd(input logic [17:0] a, exp);
    i_m.step(10'h2af, a, 18'h0);
    i_m.step(10'h3af, 18'h0, 18'h0);
    chk("first_oe", 18'h1, {17'h0, doe_n});
    i_m.step(10'h3af, 18'h0, 18'h0);
    chk("rdata", exp, dout);
    chk("oe", 18'h0, {17'h0, doe_n});
  endtask
  task automatic t_write;
    i_m.step(10'h2a7, 18'h5, 18'h15a5a);
    i_m.step(10'h0a7, 18'h5, 18'h3ffff);
    i_m.step(10'h3aa, 18'h5, 18'h00123);
    rd(18'h5, {9'h0ad, 9'h123});
    @(posedge core_clk) i_m.oe_lvl <= 1'b1;
    i_m.oe_n_out <= 1'b1;
    #1 chk("oe_async", 18'h1, {17'h0, doe_n});
    i_m.oe_lvl = 1'b0;
  endtask
  task automatic t_burst(input logic lin);
    logic [1:0] off;
    @(posedge core_clk) i_m.strap_out <= !lin;
    i_m.step(10'h2a7, 18'h8, 18'h100);
    // burst write: each advance writes the next address of the group
    for (int i = 1; i < 4; i++) begin
      i_m.step(10'h327, 18'h0, 18'h100 + 18'(i));
    end
    i_m.step(10'h2af, 18'h9, 18'h0);
    i_m.step(10'h32f, 18'h0, 18'h0);
    for (int i = 0; i < 4; i++) begin
      i_m.step(i < 2 ? 10'h32f : 10'h3af, 18'h0, 18'h0);
      off = lin ? 2'(1 + i) : 2'(1 ^ i);
      chk("burst", 18'h100 + 18'(off), dout);
    end
  endtask
  task automatic t_select;
    bus_ctrl_t pat [3] = '{10'h2ef, 10'h28f, 10'h2bf};
    for (int j = 0; j < 3; j++) begin
      i_m.step(10'h2af, 18'hb, 18'h0);
      i_m.step(10'h3af, 18'h0, 18'h0);
      i_m.step(j == 0 ? 10'h1ef : pat[j], 18'h8, 18'h0);
      chk("sel_oe", 18'h0, {17'h0, doe_n});
      i_m.step(pat[j], 18'h8, 18'h0);
      chk("cs1_proc", 18'h103, dout);
      chk("cs1_proc_oe", {17'h0, j != 0}, {17'h0, doe_n});
      i_m.step(10'h3af, 18'h0, 18'h0);
      chk("desel_oe", 18'h1, {17'h0, doe_n});
    end
  endtask
  task automatic t_sleep;
    // open a read first so that sleep has driven pins to park
    i_m.step(10'h2af, 18'h5, 18'h0);
    @(posedge core_clk) i_m.sleep_out <= 1'b1;
    repeat (3) i_m.step(10'h3af, 18'h0, 18'h0);
    chk("sleep_park", 18'h1, {17'h0, doe_n});
    i_m.step(10'h2a7, 18'h5, 18'h3ffff);
    i_m.step(10'h3af, 18'h0, 18'h0);
    chk("sleep_oe", 18'h1, {17'h0, doe_n});
    @(posedge core_clk) i_m.sleep_out <= 1'b0;
    repeat (3) i_m.step(10'h3af, 18'h0, 18'h0);
    rd(18'h5, {9'h0ad, 9'h123});
  endtask
  task automatic print_verdict;
    $display("checks %0d errors %0d", tests_run, error_cnt);
    if (error_cnt == 0 && tests_run > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  initial begin
    core_clk = 1'b0;
    forever #20 core_clk = ~core_clk;
  end
  always @(posedge core_clk) begin
    cycles++;
    if (cycles == 2000) begin
      error_cnt++;
      print_verdict();
    end
  end
  initial begin
    rst_n = 1'b0;
    repeat (8) @(posedge core_clk);
    rst_n <= 1'b1;
    repeat (3) @(posedge core_clk);
    t_write();
    t_burst(1'b0);
    t_burst(1'b1);
    t_select();
    t_sleep();
    print_verdict();
  end
endmodule
